// ### logic/aicc_core.sv
/*
 * Pin level logic of the audio signal processor: input and clock selection,
 * mirror and TDM capture pins, two channel capture output, master clock out,
 * boot timer, silence flag, noise test pin, SPI readback pin and mute ramp.
 * Assumes ref_clk at 100 MHz, far above every pin clock, and a core
 * that supplies program counter, trap values and data.
 */
// What this block does
// - Mirror pins follow selected group when enabled in mode 00
// - Mode 01 switches dual pins to TDM
// - TDM drives 256fs clock, sync, six channels
// - Six traps load TDM channels on match
// - Left and right traps load capture output
// - Capture output timed by selected input clocks
// - Master clock input chosen from three pins
// - Ratio bit declares 256 or 512 fs
// - Master clock output: off, 256, and a copy in both 512 and copy modes
// - SPI output driven only during reads
// - SPI works with gated or free clock
// - Boot clears state within 1024 master clocks
// - Silence flag after 1024 zero frames
// - Test code 7 routes noise to flag
// - Noise at 128fs, 24 bit sequence
// - Aux input sampled on selected clocks
// - Mute ramps volume down and back up
// - Input group chosen from three groups
// - Format code sets input and capture format
`timescale 1ns/1ns
`default_nettype none
module aicc_core (
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             srst,
    // Pins from outside
    input  wire logic                             reset_low,
    input  wire logic                             master_clock_in_first,
    input  wire logic                             master_clock_in_second,
    input  wire logic                             master_clock_in_third,
    input  wire logic [2:0]                       serial_audio_in,
    input  wire logic [2:0]                       frame_clock_in,
    input  wire logic [2:0]                       bit_clock_in,
    input  wire logic                             aux_serial_in,
    input  wire logic                             mute_in,
    // SPI pins
    input  wire logic                             spi_serial_in,
    input  wire logic                             spi_bit_clock,
    input  wire logic                             spi_latch,
    output logic                                  spi_serial_out,
    output logic                                  spi_serial_oe_n,
    // Control settings
    input  wire logic [3:0]                       serial_format,
    input  wire logic [1:0]                       capture_mode,
    input  wire logic                             mirror_enable,
    input  wire logic [1:0]                       input_group_sel,
    input  wire logic [1:0]                       master_clock_sel,
    input  wire logic                             master_clock_ratio_sel,
    input  wire logic [1:0]                       master_clock_out_mode,
    input  wire logic [aicc_pkg::TEST_W-1:0]      test_code,
    input  wire logic [aicc_pkg::VOL_W-1:0]       volume_setting,
    // Processor core side
    input  wire logic [aicc_pkg::PC_W-1:0]        program_counter,
    input  wire logic [aicc_pkg::SAMPLE_W-1:0]    dsp_register,
    input  wire logic [aicc_pkg::PC_W-1:0]        trap_value [aicc_pkg::CH_TOTAL],
    input  wire logic [aicc_pkg::SAMPLE_W-1:0]    spi_read_data,
    output logic [aicc_pkg::SPI_ADDR_W-1:0]       spi_read_addr,
    output logic                                  spi_read_req,
    output logic                                  boot_busy,
    output logic [aicc_pkg::VOL_W-1:0]            volume_gain,
    output logic                                  aux_sample_bit,
    output logic                                  aux_sample_strobe,
    // Output pins
    output logic                                  mirror_data_out,
    output logic                                  mirror_frame_out,
    output logic                                  mirror_bitclk_out,
    output logic                                  capture_serial_out,
    output logic                                  master_clock_out,
    output logic                                  zero_input_flag
);

    function automatic logic pick3(input logic [2:0] v, input logic [1:0] s);
        return (s == 2'h2) ? v[2] : (s == 2'h1) ? v[1] : v[0];
    endfunction

    // Two flip-flop synchronisers for every outside pin.
    logic [aicc_pkg::SYNC_W-1:0] raw;
    logic [aicc_pkg::SYNC_W-1:0] meta_q;
    logic [aicc_pkg::SYNC_W-1:0] sync_q;
    logic [aicc_pkg::SYNC_W-1:0] prev_q;
    assign raw = {mute_in, reset_low, spi_latch, spi_bit_clock, spi_serial_in,
                  aux_serial_in, bit_clock_in, frame_clock_in, serial_audio_in,
                  master_clock_in_third, master_clock_in_second,
                  master_clock_in_first};
    always_ff @(posedge ref_clk) begin
        meta_q <= raw;
        sync_q <= meta_q;
        prev_q <= sync_q;
    end

    // Selected master clock and serial group.
    logic mclk;
    logic mclk_rise;
    aicc_pkg::aicc_group_s grp;
    aicc_pkg::aicc_group_s grp_prev;
    logic frame_edge;
    logic frame_rise;
    logic bit_rise;
    logic bit_fall;
    logic aux;
    assign mclk = pick3(sync_q[aicc_pkg::SY_MCLK+:3], master_clock_sel);
    assign mclk_rise = mclk & ~pick3(prev_q[aicc_pkg::SY_MCLK+:3],
                                      master_clock_sel);
    always_comb begin
        grp.data = pick3(sync_q[aicc_pkg::SY_DATA+:3], input_group_sel);
        grp.frame = pick3(sync_q[aicc_pkg::SY_FRAME+:3], input_group_sel);
        grp.bitclk = pick3(sync_q[aicc_pkg::SY_BIT+:3], input_group_sel);
        grp_prev.data = pick3(prev_q[aicc_pkg::SY_DATA+:3], input_group_sel);
        grp_prev.frame = pick3(prev_q[aicc_pkg::SY_FRAME+:3], input_group_sel);
        grp_prev.bitclk = pick3(prev_q[aicc_pkg::SY_BIT+:3], input_group_sel);
    end
    assign frame_edge = grp.frame ^ grp_prev.frame;
    assign frame_rise = grp.frame & ~grp_prev.frame;
    assign bit_rise = grp.bitclk & ~grp_prev.bitclk;
    assign bit_fall = ~grp.bitclk & grp_prev.bitclk;
    assign aux = sync_q[aicc_pkg::SY_AUX];

    // Boot timer counts selected master clock edges after reset release.
    logic dev_rst;
    logic [10:0] init_cnt_q;
    logic boot_busy_q;
    assign dev_rst = srst | ~sync_q[aicc_pkg::SY_RST_LOW];
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            init_cnt_q <= 11'h000;
            boot_busy_q <= 1'b1;
        end else if (boot_busy_q && mclk_rise) begin
            init_cnt_q <= init_cnt_q + 11'h001;
            if (init_cnt_q == aicc_pkg::INIT_MCLK_LAST) begin
                boot_busy_q <= 1'b0;
            end
        end
    end
    assign boot_busy = boot_busy_q;

    // Trap captures, cleared during boot.
    logic [aicc_pkg::SAMPLE_W-1:0] hold_q [aicc_pkg::CH_TOTAL];
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < aicc_pkg::CH_TOTAL; i++) begin
            if (boot_busy_q) begin
                hold_q[i] <= '0;
            end else if (program_counter == trap_value[i]) begin
                hold_q[i] <= dsp_register;
            end
        end
    end

    // Two channel capture output in the input port format.
    logic [aicc_pkg::SAMPLE_W-1:0] dcs_sh_q;
    logic [aicc_pkg::SAMPLE_W-1:0] dcs_word;
    logic dcs_q;
    logic fmt_i2s;
    assign fmt_i2s = serial_format == aicc_pkg::FMT_I2S;
    assign dcs_word = (grp.frame ^ fmt_i2s) ? hold_q[0] : hold_q[1];
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            dcs_sh_q <= '0;
            dcs_q <= 1'b0;
        end else if (frame_edge) begin
            if (fmt_i2s) begin
                dcs_sh_q <= dcs_word;
            end else begin
                dcs_q <= dcs_word[aicc_pkg::SAMPLE_W-1];
                dcs_sh_q <= {dcs_word[aicc_pkg::SAMPLE_W-2:0], 1'b0};
            end
        end else if (bit_fall) begin
            dcs_q <= dcs_sh_q[aicc_pkg::SAMPLE_W-1];
            dcs_sh_q <= {dcs_sh_q[aicc_pkg::SAMPLE_W-2:0], 1'b0};
        end
    end
    assign capture_serial_out = dcs_q;

    // Auxiliary input bits handed to the core on the selected bit clock.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            aux_sample_bit <= 1'b0;
            aux_sample_strobe <= 1'b0;
        end else begin
            aux_sample_strobe <= bit_rise;
            if (bit_rise) begin
                aux_sample_bit <= aux;
            end
        end
    end

    // 256 fs clock: half the master clock at 512 fs, else a copy of it.
    logic tdm_clk_q;
    logic tdm_clk_d;
    logic tdm_fall;
    always_comb begin
        tdm_clk_d = mclk;
        if (!master_clock_ratio_sel) begin
            tdm_clk_d = tdm_clk_q ^ mclk_rise;
        end
    end
    assign tdm_fall = tdm_clk_q & ~tdm_clk_d;
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            tdm_clk_q <= 1'b0;
        end else begin
            tdm_clk_q <= tdm_clk_d;
        end
    end

    // TDM frame of eight 32 bit slots, six of them carrying captures.
    logic [7:0] tdm_cnt_q;
    logic [7:0] tdm_cnt_d;
    logic tdm_resync_q;
    logic [31:0] tdm_sh_q;
    logic [aicc_pkg::SAMPLE_W-1:0] tdm_snap_q [aicc_pkg::TDM_SLOTS];
    logic tdm_data_q;
    logic tdm_fs_q;
    logic [2:0] slot;
    assign tdm_cnt_d = tdm_resync_q ? 8'h00 : tdm_cnt_q + 8'h01;
    assign slot = tdm_cnt_d[7:5];
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            tdm_cnt_q <= 8'hFF;
            tdm_resync_q <= 1'b0;
            tdm_sh_q <= '0;
            tdm_data_q <= 1'b0;
            tdm_fs_q <= 1'b0;
            for (int i = 0; i < aicc_pkg::TDM_SLOTS; i++) begin
                tdm_snap_q[i] <= '0;
            end
        end else begin
            if (frame_rise) begin
                tdm_resync_q <= 1'b1;
            end else if (tdm_fall) begin
                tdm_resync_q <= 1'b0;
            end
            if (tdm_fall) begin
                tdm_cnt_q <= tdm_cnt_d;
                tdm_fs_q <= tdm_cnt_d == 8'h00;
                if (tdm_cnt_d == 8'h00) begin
                    for (int i = 0; i < aicc_pkg::TDM_SLOTS; i++) begin
                        tdm_snap_q[i] <= hold_q[aicc_pkg::TDM_FIRST + i];
                    end
                end
                if (tdm_cnt_d[4:0] == 5'h00) begin
                    if (tdm_cnt_d == 8'h00) begin
                        tdm_data_q <= hold_q[aicc_pkg::TDM_FIRST]
                                            [aicc_pkg::SAMPLE_W-1];
                        tdm_sh_q <= {hold_q[aicc_pkg::TDM_FIRST], 8'h00} << 1;
                    end else if (32'(slot) < aicc_pkg::TDM_SLOTS) begin
                        tdm_data_q <= tdm_snap_q[slot][aicc_pkg::SAMPLE_W-1];
                        tdm_sh_q <= {tdm_snap_q[slot], 8'h00} << 1;
                    end else begin
                        tdm_data_q <= 1'b0;
                        tdm_sh_q <= '0;
                    end
                end else begin
                    tdm_data_q <= tdm_sh_q[31];
                    tdm_sh_q <= {tdm_sh_q[30:0], 1'b0};
                end
            end
        end
    end

    // Dual function pins: TDM, mirror or idle low.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            mirror_data_out <= 1'b0;
            mirror_frame_out <= 1'b0;
            mirror_bitclk_out <= 1'b0;
        end else if (capture_mode == aicc_pkg::CAPMODE_TDM) begin
            mirror_data_out <= tdm_data_q;
            mirror_frame_out <= tdm_fs_q;
            mirror_bitclk_out <= tdm_clk_q;
        end else if (mirror_enable &&
                     capture_mode == aicc_pkg::CAPMODE_OFF) begin
            mirror_data_out <= grp.data;
            mirror_frame_out <= grp.frame;
            mirror_bitclk_out <= grp.bitclk;
        end else begin
            mirror_data_out <= 1'b0;
            mirror_frame_out <= 1'b0;
            mirror_bitclk_out <= 1'b0;
        end
    end

    // Master clock output.
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            master_clock_out <= 1'b0;
        end else begin
            unique case (master_clock_out_mode)
                aicc_pkg::MCO_OFF: master_clock_out <= 1'b0;
                aicc_pkg::MCO_256: master_clock_out <= tdm_clk_q;
                aicc_pkg::MCO_512: master_clock_out <= mclk;
                aicc_pkg::MCO_COPY: master_clock_out <= mclk;
            endcase
        end
    end

    // Silence detector over main and auxiliary inputs.
    logic [10:0] zero_cnt_q;
    logic nonzero_q;
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            zero_cnt_q <= 11'h000;
            nonzero_q <= 1'b0;
        end else if (frame_rise) begin
            nonzero_q <= 1'b0;
            if (nonzero_q || (bit_rise && (grp.data || aux))) begin
                zero_cnt_q <= 11'h000;
            end else if (zero_cnt_q != aicc_pkg::ZERO_FRAMES) begin
                zero_cnt_q <= zero_cnt_q + 11'h001;
            end
        end else if (bit_rise && (grp.data || aux)) begin
            nonzero_q <= 1'b1;
        end
    end

    // Noise generator stepping at 128 fs.
    logic [1:0] noise_div_q;
    logic [1:0] noise_last;
    logic [23:0] lfsr_q;
    assign noise_last = master_clock_ratio_sel ? aicc_pkg::NOISE_DIV_256
                                               : aicc_pkg::NOISE_DIV_512;
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            noise_div_q <= 2'h0;
            lfsr_q <= aicc_pkg::NOISE_SEED;
        end else if (mclk_rise) begin
            if (noise_div_q >= noise_last) begin
                noise_div_q <= 2'h0;
                lfsr_q <= {lfsr_q[22:0], lfsr_q[23] ^ lfsr_q[22] ^
                           lfsr_q[21] ^ lfsr_q[16]};
            end else begin
                noise_div_q <= noise_div_q + 2'h1;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            zero_input_flag <= 1'b0;
        end else if (test_code == aicc_pkg::NOISE_TEST_CODE) begin
            zero_input_flag <= lfsr_q[23];
        end else begin
            zero_input_flag <= zero_cnt_q == aicc_pkg::ZERO_FRAMES;
        end
    end

    // SPI readback, framed only by the latch so a gated clock is fine.
    logic spi_act;
    logic spi_rise;
    logic spi_fall;
    logic [3:0] spi_cnt_q;
    logic [aicc_pkg::SPI_ADDR_W-1:0] spi_hdr_q;
    logic spi_rd_q;
    logic [aicc_pkg::SAMPLE_W-1:0] spi_sh_q;
    assign spi_act = ~sync_q[aicc_pkg::SY_LATCH];
    assign spi_rise = sync_q[aicc_pkg::SY_SPI_CLK] &
                      ~prev_q[aicc_pkg::SY_SPI_CLK];
    assign spi_fall = ~sync_q[aicc_pkg::SY_SPI_CLK] &
                      prev_q[aicc_pkg::SY_SPI_CLK];
    always_ff @(posedge ref_clk) begin
        if (dev_rst || !spi_act) begin
            spi_cnt_q <= 4'h0;
            spi_hdr_q <= '0;
            spi_rd_q <= 1'b0;
            spi_sh_q <= '0;
            spi_read_req <= 1'b0;
            spi_serial_out <= 1'b0;
            spi_serial_oe_n <= 1'b1;
            if (dev_rst) begin
                spi_read_addr <= '0;
            end
        end else begin
            spi_read_req <= 1'b0;
            if (spi_rise && spi_cnt_q <= aicc_pkg::SPI_HDR_LAST) begin
                spi_cnt_q <= spi_cnt_q + 4'h1;
                spi_hdr_q <= {spi_hdr_q[aicc_pkg::SPI_ADDR_W-2:0],
                              sync_q[aicc_pkg::SY_SPI_IN]};
                if (spi_cnt_q == aicc_pkg::SPI_HDR_LAST && spi_hdr_q[9]) begin
                    spi_rd_q <= 1'b1;
                    spi_read_req <= 1'b1;
                    spi_read_addr <= {spi_hdr_q[8:0],
                                      sync_q[aicc_pkg::SY_SPI_IN]};
                end
            end
            if (spi_read_req) begin
                spi_sh_q <= spi_read_data;
            end else if (spi_fall && spi_rd_q) begin
                spi_serial_oe_n <= 1'b0;
                spi_serial_out <= spi_sh_q[aicc_pkg::SAMPLE_W-1];
                spi_sh_q <= {spi_sh_q[aicc_pkg::SAMPLE_W-2:0], 1'b0};
            end
        end
    end

    // Mute ramp: one volume step per interval toward zero or the setting.
    logic [9:0] step_cnt_q;
    logic [aicc_pkg::VOL_W-1:0] vol_q;
    logic [aicc_pkg::VOL_W-1:0] vol_target;
    assign vol_target = sync_q[aicc_pkg::SY_MUTE] ? '0 : volume_setting;
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            step_cnt_q <= 10'h000;
            vol_q <= aicc_pkg::VOL_RESET;
        end else if (step_cnt_q == aicc_pkg::MUTE_STEP_LAST) begin
            step_cnt_q <= 10'h000;
            if (vol_q > vol_target) begin
                vol_q <= vol_q - 11'h001;
            end else if (vol_q < vol_target) begin
                vol_q <= vol_q + 11'h001;
            end
        end else begin
            step_cnt_q <= step_cnt_q + 10'h001;
        end
    end
    assign volume_gain = vol_q;

endmodule
`default_nettype wire

// ### shared/aicc_pkg.sv
/*
 * Constants and types shared by the audio pin, clock and capture logic.
 * Assumes a single 100 MHz system clock.
 */
`default_nettype none
package aicc_pkg;

    // Bit positions of the synchronised pins.
    localparam int SYNC_W = 18;
    localparam int SY_MCLK = 0;
    localparam int SY_DATA = 3;
    localparam int SY_FRAME = 6;
    localparam int SY_BIT = 9;
    localparam int SY_AUX = 12;
    localparam int SY_SPI_IN = 13;
    localparam int SY_SPI_CLK = 14;
    localparam int SY_LATCH = 15;
    localparam int SY_RST_LOW = 16;
    localparam int SY_MUTE = 17;

    // Data path widths.
    localparam int PC_W = 10;
    localparam int SAMPLE_W = 24;
    localparam int CH_TOTAL = 8;
    localparam int TDM_SLOTS = 6;
    localparam int TDM_FIRST = 2;
    localparam int TEST_W = 8;
    localparam int SPI_ADDR_W = 10;
    localparam int VOL_W = 11;

    // Capture pin modes.
    localparam logic [1:0] CAPMODE_OFF = 2'h0;
    localparam logic [1:0] CAPMODE_TDM = 2'h1;

    // Master clock output modes.
    localparam logic [1:0] MCO_OFF = 2'h0;
    localparam logic [1:0] MCO_256 = 2'h1;
    localparam logic [1:0] MCO_512 = 2'h2;
    localparam logic [1:0] MCO_COPY = 2'h3;

    // Serial format code with a one bit delay after the frame edge.
    localparam logic [3:0] FMT_I2S = 4'h0;

    // Counts.
    localparam logic [10:0] INIT_MCLK_LAST = 11'h3FF;
    localparam logic [10:0] ZERO_FRAMES = 11'h400;
    localparam logic [4:0] TDM_SLOT_LAST = 5'h1F;
    localparam logic [3:0] SPI_HDR_LAST = 4'hA;
    localparam logic [7:0] NOISE_TEST_CODE = 8'h07;
    localparam logic [23:0] NOISE_SEED = 24'h000001;
    localparam logic [1:0] NOISE_DIV_512 = 2'h3;
    localparam logic [1:0] NOISE_DIV_256 = 2'h1;

    // Mute ramp timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int MUTE_RAMP_NS = 10_000_000;
    localparam int VOL_STEPS = 1024;
    localparam int MUTE_STEP_CYC = MUTE_RAMP_NS / CLK_PERIOD_NS / VOL_STEPS;
    localparam logic [9:0] MUTE_STEP_LAST = 10'(MUTE_STEP_CYC - 1);

    // Reset values.
    localparam logic [VOL_W-1:0] VOL_RESET = 11'h000;

    // One serial input group as it travels together.
    typedef struct packed {
        logic data;
        logic frame;
        logic bitclk;
    } aicc_group_s;

endpackage
`default_nettype wire

// ### verif/aicc_core_properties.sv
/* Port checker for aicc_core, bound to every instance.
   Assumes the first master clock pin is the one selected during boot. */
`timescale 1ns/1ns
`default_nettype none
module aicc_core_properties (
    // Watched ports
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        master_clock_in_first,
    input wire logic [2:0]  serial_audio_in,
    input wire logic        spi_latch,
    input wire logic [1:0]  capture_mode,
    input wire logic        mirror_enable,
    input wire logic [1:0]  input_group_sel,
    input wire logic [1:0]  master_clock_out_mode,
    input wire logic        mute_in,
    input wire logic        spi_serial_oe_n,
    input wire logic        spi_read_req,
    input wire logic        boot_busy,
    input wire logic [10:0] volume_gain,
    input wire logic        mirror_data_out,
    input wire logic        master_clock_out
);
    logic [2:0]  mc_q;
    logic [10:0] n_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Master clock rises during boot.
    always_ff @(posedge ref_clk) begin
        mc_q <= {mc_q[1:0], master_clock_in_first};
        if (srst || !boot_busy) n_q <= 11'h000;
        else if (mc_q[1] && !mc_q[2]) n_q <= n_q + 11'h001;
    end
    a_boot_not_long: assert property (boot_busy |-> n_q <= 11'h402)
        else $error("boot too long");
    a_boot_not_short: assert property ($fell(boot_busy) |-> n_q >= 11'h3FD)
        else $error("boot ends too early");
    a_reset_state: assert property ($fell(srst) |->
        boot_busy && spi_serial_oe_n && volume_gain == 11'h000)
        else $error("bad reset state");
    a_mirror_follow: assert property ((mirror_enable
        && capture_mode == aicc_pkg::CAPMODE_OFF && input_group_sel < 2'h3
        && $stable(input_group_sel) && $stable(serial_audio_in)) [*6]
        |-> mirror_data_out == serial_audio_in[input_group_sel])
        else $error("mirror data wrong");
    a_mirror_off: assert property ((!mirror_enable
        && capture_mode == aicc_pkg::CAPMODE_OFF) [*4] |-> !mirror_data_out)
        else $error("mirror not off");
    a_mclk_out_off: assert property (
        master_clock_out_mode == aicc_pkg::MCO_OFF [*4] |-> !master_clock_out)
        else $error("clock out not off");
    a_spi_out_idle: assert property (spi_latch [*4] |-> spi_serial_oe_n)
        else $error("SPI out driven idle");
    a_read_pulse: assert property (spi_read_req |-> !spi_latch ##1 !spi_read_req)
        else $error("bad read request");
    a_mute_down: assert property (mute_in [*4]
        |-> volume_gain <= $past(volume_gain))
        else $error("volume rose in mute");
    a_ramp_pace: assert property ($changed(volume_gain)
        |=> $stable(volume_gain) [*8])
        else $error("volume steps too fast");
    cover property (spi_read_req);
    cover property ($fell(boot_busy));
    cover property ($changed(volume_gain));
endmodule
bind aicc_core aicc_core_properties aicc_core_properties_inst (.*);
`default_nettype wire

// ### verif/aicc_partner.sv
/* Serial audio source: three master clocks and three input groups.
   Assumes a free running source at 512 fs; data changes on bit clock falls. */
`timescale 1ns/1ns
`default_nettype none
module aicc_partner (
    // Source pins
    output logic       master_clock_in_first = 1'b0,
    output logic       master_clock_in_second = 1'b0,
    output logic       master_clock_in_third = 1'b0,
    output logic [2:0] serial_audio_in,
    output logic [2:0] frame_clock_in,
    output logic [2:0] bit_clock_in,
    output logic       aux_serial_in
);
    logic [10:0] n = 11'h000;
    always #80 master_clock_in_first = ~master_clock_in_first;
    always #70 master_clock_in_second = ~master_clock_in_second;
    always #60 master_clock_in_third = ~master_clock_in_third;
    always @(posedge master_clock_in_first) n <= n + 11'h001;
    assign bit_clock_in = {3{n[2]}};
    assign frame_clock_in = {3{n[8]}};
    assign serial_audio_in = {n[5], n[4], n[3]};
    assign aux_serial_in = n[6];
endmodule
`default_nettype wire

// ### verif/test_audio_io_clock_capture.sv
/* Self-checking bench for aicc_core with the serial source model.
   Assumes bounded waits suffice. */
`timescale 1ns/1ns
`default_nettype none
module test_audio_io_clock_capture;
    logic        ref_clk = 1'b0, srst = 1'b1, reset_low = 1'b1;
    logic        mute_in = 1'b0, spi_serial_in = 1'b0;
    logic        spi_bit_clock = 1'b0, spi_latch = 1'b1;
    logic [3:0]  serial_format = 4'h0;
    logic [1:0]  capture_mode = 2'h0, input_group_sel = 2'h0;
    logic [1:0]  master_clock_sel = 2'h0, master_clock_out_mode = 2'h0;
    logic        mirror_enable = 1'b0, master_clock_ratio_sel = 1'b0;
    logic [7:0]  test_code = 8'h00;
    logic [10:0] volume_setting = 11'h004;
    logic [9:0]  program_counter = 10'h000;
    logic [23:0] dsp_register = 24'h000000;
    logic [9:0]  trap_value [8] = '{default: 10'h3FF};
    logic        master_clock_in_first, master_clock_in_second;
    logic        master_clock_in_third, aux_serial_in;
    logic [2:0]  serial_audio_in, frame_clock_in, bit_clock_in;
    logic        spi_serial_out, spi_serial_oe_n, spi_read_req, boot_busy;
    logic        aux_sample_bit, aux_sample_strobe, capture_serial_out;
    logic        mirror_data_out, mirror_frame_out, mirror_bitclk_out;
    logic        master_clock_out, zero_input_flag;
    logic [9:0]  spi_read_addr;
    logic [10:0] volume_gain;
    wire  [23:0] spi_read_data = {14'h2E1B, spi_read_addr};
    wire  [5:0]  s = {mirror_frame_out, mirror_data_out, capture_serial_out,
                      zero_input_flag, master_clock_out, mirror_bitclk_out};
    int          r [6];
    int          errors = 0, total_checks = 0, cyc = 0, n;
    aicc_core aicc_core_inst (.*);
    aicc_partner aicc_partner_inst (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            stop_test;
        end
    end
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc_wait(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic count(input int k);
        logic [5:0] p;
        p = s;
        r = '{default: 0};
        repeat (k) begin
            @(negedge ref_clk);
            for (int i = 0; i < 6; i++) r[i] += (s[i] && !p[i]);
            p = s;
        end
    endtask
    task automatic spi_bit(input logic b);
        spi_serial_in = b;
        cyc_wait(8);
        spi_bit_clock = 1'b1;
        cyc_wait(8);
        spi_bit_clock = 1'b0;
    endtask
    task automatic spi_read(input logic [9:0] a);
        spi_latch = 1'b0;
        cyc_wait(8);
        spi_bit(1'b1);
        for (int i = 9; i >= 0; i--) spi_bit(a[i]);
        check(spi_read_addr, a);
        for (int i = 23; i >= 0; i--) begin
            cyc_wait(8);
            check({spi_serial_oe_n, spi_serial_out}, {1'b0, spi_read_data[i]});
            spi_bit_clock = 1'b1;
            cyc_wait(8);
            spi_bit_clock = 1'b0;
        end
        spi_latch = 1'b1;
        cyc_wait(8);
        check(spi_serial_oe_n, 1'b1);
    endtask
    initial begin
        cyc_wait(8);
        check({boot_busy, spi_serial_oe_n, volume_gain}, 13'h1800);
        cyc_wait(8);
        srst = 1'b0;
        n = 0;
        while (boot_busy !== 1'b0 && n < 20000) begin
            cyc_wait(1);
            n++;
        end
        check(n > 16300 && n < 16500, 1'b1);
        spi_read(10'h107);
        spi_read(10'h1FF);
        mirror_enable = 1'b1;
        for (int g = 0; g < 3; g++) begin
            input_group_sel = 2'(g);
            count(1100);
            check(r[0] > 7 && r[0] < 10 && r[4] > 0, 1'b1);
            check(r[2] + r[3], 0);
        end
        mirror_enable = 1'b0;
        count(200);
        check(r[0] + r[4], 0);
        program_counter = 10'h005;
        dsp_register = 24'h800001;
        trap_value[0] = 10'h005;
        trap_value[2] = 10'h005;
        capture_mode = aicc_pkg::CAPMODE_TDM;
        count(16384);
        check(r[0] > 509 && r[0] < 515, 1'b1);
        check(r[5] > 0 && r[5] < 4, 1'b1);
        check(r[4] > 0 && r[3] > 0, 1'b1);
        capture_mode = aicc_pkg::CAPMODE_OFF;
        for (int m = 1; m < 4; m++) begin
            master_clock_out_mode = 2'(m);
            count(40);
            count(1600);
            n = (m == 1) ? 50 : 100;
            check(r[1] > n - 3 && r[1] < n + 3, 1'b1);
        end
        master_clock_out_mode = aicc_pkg::MCO_OFF;
        test_code = aicc_pkg::NOISE_TEST_CODE;
        count(3200);
        check(r[2] > 0 && r[2] < 26, 1'b1);
        check(volume_gain, 11'h004);
        mute_in = 1'b1;
        cyc_wait(5000);
        check(volume_gain, 11'h000);
        mute_in = 1'b0;
        cyc_wait(5000);
        check(volume_gain, 11'h004);
        stop_test;
    end
endmodule
`default_nettype wire
